// ---- common/bxd_pkg.sv ----
package bxd_pkg;

    // Master clock
    localparam int unsigned MCLK_PERIOD_NS = 20;

    // Dead interval between one phase falling and the other rising: one master clock period
    localparam int unsigned GAP_TIME_NS    = 20;
    localparam int unsigned GAP_CYCLES_RAW = (GAP_TIME_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    localparam int unsigned GAP_CYCLES     = (GAP_CYCLES_RAW < 1) ? 1 : GAP_CYCLES_RAW;

    // Length of each driven phase when the internal timer paces the toggling
    localparam int unsigned HALF_PERIOD_CYCLES = 64;

    // Counter widths
    localparam int unsigned GAP_CNT_W   = 4;
    localparam int unsigned HALF_CNT_W  = 16;

    localparam logic [GAP_CNT_W-1:0]  GAP_LAST  = GAP_CNT_W'(GAP_CYCLES - 1);
    localparam logic [HALF_CNT_W-1:0] HALF_LAST = HALF_CNT_W'(HALF_PERIOD_CYCLES - 1);
    localparam logic [GAP_CNT_W-1:0]  GAP_RST   = 4'h0;
    localparam logic [HALF_CNT_W-1:0] HALF_RST  = 16'h0000;

    // Levels while excitation is off
    localparam logic PARK_PHASE_A = 1'b1;
    localparam logic PARK_PHASE_B = 1'b0;

    // Drive sequencer states
    typedef enum logic [4:0] {
        BXD_PARK   = 5'h01,
        BXD_A_ON   = 5'h02,
        BXD_GAP_AB = 5'h04,
        BXD_B_ON   = 5'h08,
        BXD_GAP_BA = 5'h10
    } bxd_state_t;

    localparam bxd_state_t STATE_RST = BXD_PARK;

endpackage

// ---- hdl/bxd_half_timer.sv ----
`timescale 1ns/100ps
`default_nettype none

module bxd_half_timer (
    // Clock and reset
    input  wire logic                           mclk_in,
    input  wire logic                           sys_rst_in,
    input  wire logic                           ce_in,
    // Control
    input  wire logic                           restart_in,
    // Pace
    output logic                                tick_out
);
    import bxd_pkg::*;

    logic [HALF_CNT_W-1:0] cnt_q;

    // Counts one phase length; restart realigns it to a phase start
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            cnt_q <= HALF_RST;
        end else if (ce_in) begin
            if (restart_in || cnt_q == HALF_LAST) begin
                cnt_q <= HALF_RST;
            end else begin
                cnt_q <= cnt_q + HALF_CNT_W'(1);
            end
        end
    end

    assign tick_out = ce_in && !restart_in && (cnt_q == HALF_LAST);

endmodule

`default_nettype wire

// ---- hdl/bxd_excite_drive.sv ----
// Notes on behaviour
// - When enabled, phase B toggles opposite to phase A, with both low during each dead interval.
// - One master clock dead interval between one phase falling and the other rising.
// - With enable low, phase B is held low.
// - Phase B complement is the inverse of phase B, high when disabled.
// - Phase A high means normal polarity, low means reversed polarity.
// - With enable low, phase A is held high, from the end of the dead interval if phase B was on.
// - Phase A complement is the inverse of phase A, low when disabled.
`timescale 1ns/100ps
`default_nettype none

module bxd_excite_drive (
    // Clock, reset, enable
    input  wire logic                           mclk_in,
    input  wire logic                           sys_rst_in,
    input  wire logic                           ce_in,
    // Control from same-clock logic
    input  wire logic                           ac_excite_enable_in,
    input  wire logic                           ext_step_sel_in,
    input  wire logic                           ext_step_in,
    // Bridge switch drive
    output logic                                excite_phase_a_out,
    output logic                                excite_phase_a_n_out,
    output logic                                excite_phase_b_out,
    output logic                                excite_phase_b_n_out,
    // Status
    output logic                                polarity_reversed_out,
    output logic                                excite_active_out
);
    import bxd_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Output decode per state

    function automatic logic phase_a_of(input bxd_state_t s);
        phase_a_of = (s == BXD_PARK) || (s == BXD_A_ON);
    endfunction

    function automatic logic phase_b_of(input bxd_state_t s);
        phase_b_of = (s == BXD_B_ON);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pacing

    bxd_state_t            state_q;
    bxd_state_t            state_d;
    logic [GAP_CNT_W-1:0]  gap_cnt_q;
    logic                  gap_done;
    logic                  timer_tick;
    logic                  timer_restart;
    logic                  step;

    // Timer restarts at every phase start so each driven phase is full length
    assign timer_restart = (state_q != BXD_A_ON) && (state_q != BXD_B_ON);

    bxd_half_timer u_half_timer (
        .mclk_in    (mclk_in),
        .sys_rst_in (sys_rst_in),
        .ce_in      (ce_in),
        .restart_in (timer_restart),
        .tick_out   (timer_tick)
    );

    assign step     = ext_step_sel_in ? ext_step_in : timer_tick;
    assign gap_done = (gap_cnt_q == GAP_LAST);

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer

    always_comb begin
        state_d = state_q;
        case (state_q)
            BXD_PARK: begin
                if (ac_excite_enable_in) begin
                    state_d = BXD_A_ON;
                end
            end
            BXD_A_ON: begin
                if (!ac_excite_enable_in) begin
                    state_d = BXD_PARK;
                end else if (step) begin
                    state_d = BXD_GAP_AB;
                end
            end
            BXD_GAP_AB: begin
                if (!ac_excite_enable_in) begin
                    state_d = BXD_PARK;
                end else if (gap_done) begin
                    state_d = BXD_B_ON;
                end
            end
            BXD_B_ON: begin
                // Even on disable, B falls first and A returns after the gap
                if (!ac_excite_enable_in || step) begin
                    state_d = BXD_GAP_BA;
                end
            end
            BXD_GAP_BA: begin
                if (gap_done) begin
                    state_d = ac_excite_enable_in ? BXD_A_ON : BXD_PARK;
                end
            end
            default: begin
                state_d = BXD_PARK;
            end
        endcase
    end

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            state_q <= STATE_RST;
        end else if (ce_in) begin
            state_q <= state_d;
        end
    end

    // Dead interval counter, runs only in the gap states
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            gap_cnt_q <= GAP_RST;
        end else if (ce_in) begin
            if (state_d == BXD_GAP_AB || state_d == BXD_GAP_BA) begin
                if (state_d != state_q) begin
                    gap_cnt_q <= GAP_RST;
                end else begin
                    gap_cnt_q <= gap_cnt_q + GAP_CNT_W'(1);
                end
            end else begin
                gap_cnt_q <= GAP_RST;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registered switch drive

    logic phase_a_q;
    logic phase_a_n_q;
    logic phase_b_q;
    logic phase_b_n_q;
    logic active_q;

    // Phase A pair, both legs from one decode so they never disagree
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            phase_a_q   <= PARK_PHASE_A;
            phase_a_n_q <= ~PARK_PHASE_A;
        end else if (ce_in) begin
            phase_a_q   <= phase_a_of(state_d);
            phase_a_n_q <= ~phase_a_of(state_d);
        end
    end

    // Phase B pair, high only in its own driven state
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            phase_b_q   <= PARK_PHASE_B;
            phase_b_n_q <= ~PARK_PHASE_B;
        end else if (ce_in) begin
            phase_b_q   <= phase_b_of(state_d);
            phase_b_n_q <= ~phase_b_of(state_d);
        end
    end

    // Status follows the sequencer, parked means excitation off

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            active_q <= 1'b0;
        end else if (ce_in) begin
            active_q <= (state_d != BXD_PARK);
        end
    end

    assign excite_phase_a_out    = phase_a_q;
    assign excite_phase_a_n_out  = phase_a_n_q;
    assign excite_phase_b_out    = phase_b_q;
    assign excite_phase_b_n_out  = phase_b_n_q;
    assign polarity_reversed_out = phase_a_n_q;
    assign excite_active_out     = active_q;

endmodule

`default_nettype wire

// ---- verif/bxd_switch_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module bxd_switch_model (
    // Switch drive
    input  wire logic mclk_in,
    input  wire logic sw_a_in,
    input  wire logic sw_b_in,
    // Bridge state
    output logic      reversed_out,
    output logic      shorted_out
);
    // Bridge sees reversed excitation only while the B leg conducts
    assign reversed_out = sw_b_in;
    // Latches any cycle with both legs closed, which would short the supply
    logic shorted_q = 1'b0;
    always @(posedge mclk_in) begin
        if (sw_a_in && sw_b_in) begin
            shorted_q <= 1'b1;
        end
    end
    assign shorted_out = shorted_q;
endmodule
`default_nettype wire

// ---- verif/bxd_excite_drive_properties.sv ----
`timescale 1ns/100ps
`default_nettype none
module bxd_excite_drive_properties (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic ce_in,
    input wire logic ac_excite_enable_in,
    input wire logic excite_phase_a_out,
    input wire logic excite_phase_a_n_out,
    input wire logic excite_phase_b_out,
    input wire logic excite_phase_b_n_out
);
    wire a  = excite_phase_a_out;
    wire b  = excite_phase_b_out;
    wire en = ac_excite_enable_in;
    default clocking @(posedge mclk_in); endclocking
    default disable iff (sys_rst_in);
    property p_a_n; excite_phase_a_n_out == !a; endproperty
    a_a_n: assert property (p_a_n) else $error("phase A complement wrong");
    property p_b_n; excite_phase_b_n_out == !b; endproperty
    a_b_n: assert property (p_b_n) else $error("phase B complement wrong");
    property p_gap_ab; $rose(b) |-> !a && !$past(a); endproperty
    a_gap_ab: assert property (p_gap_ab) else $error("no gap before B");
    property p_gap_ba; $rose(a) |-> !b && !$past(b); endproperty
    a_gap_ba: assert property (p_gap_ba) else $error("no gap before A");
    property p_park_b; !en && ce_in |=> !b; endproperty
    a_park_b: assert property (p_park_b) else $error("B not low when off");
    property p_park_a; (!en && ce_in) [*2] |=> a; endproperty
    a_park_a: assert property (p_park_a) else $error("A not high when off");
    property p_freeze; !ce_in |=> $stable(a) && $stable(b); endproperty
    a_freeze: assert property (p_freeze) else $error("output moved off edge");
    property p_excl; !(a && b); endproperty
    a_excl: assert property (p_excl) else $error("phases overlap");
endmodule
bind bxd_excite_drive bxd_excite_drive_properties i_props (.mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in), .ce_in(ce_in), .ac_excite_enable_in(ac_excite_enable_in),
    .excite_phase_a_out(excite_phase_a_out), .excite_phase_a_n_out(excite_phase_a_n_out),
    .excite_phase_b_out(excite_phase_b_out), .excite_phase_b_n_out(excite_phase_b_n_out));
`default_nettype wire

// ---- verif/bxd_excite_drive_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module bxd_excite_drive_tb_top;
    import bxd_pkg::*;
    typedef struct {logic en; logic st; int cyc; logic a; logic b; logic act;} bxd_row_t;
    logic mclk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic ce_in = 1'b1;
    logic en = 1'b0;
    logic sel = 1'b1;
    logic step = 1'b0;
    wire logic a, an, b, bn, pol, act, rev, sh;
    int mismatches = 0;
    int tests_run = 0;
    int n;
    bxd_row_t rows [17] = '{
        '{1'h0, 1'h0, 2, 1'h1, 1'h0, 1'h0}, '{1'h1, 1'h0, 3, 1'h1, 1'h0, 1'h1},
        '{1'h1, 1'h1, 1, 1'h0, 1'h0, 1'h1}, '{1'h1, 1'h0, 1, 1'h0, 1'h1, 1'h1},
        '{1'h1, 1'h1, 1, 1'h0, 1'h0, 1'h1}, '{1'h1, 1'h0, 1, 1'h1, 1'h0, 1'h1},
        '{1'h1, 1'h1, 1, 1'h0, 1'h0, 1'h1}, '{1'h0, 1'h0, 1, 1'h1, 1'h0, 1'h0},
        '{1'h1, 1'h0, 1, 1'h1, 1'h0, 1'h1}, '{1'h1, 1'h1, 1, 1'h0, 1'h0, 1'h1},
        '{1'h1, 1'h0, 1, 1'h0, 1'h1, 1'h1}, '{1'h0, 1'h0, 1, 1'h0, 1'h0, 1'h1},
        '{1'h0, 1'h0, 1, 1'h1, 1'h0, 1'h0}, '{1'h1, 1'h0, 1, 1'h1, 1'h0, 1'h1},
        '{1'h0, 1'h1, 1, 1'h1, 1'h0, 1'h0}, '{1'h0, 1'h1, 1, 1'h1, 1'h0, 1'h0},
        '{1'h0, 1'h0, 1, 1'h1, 1'h0, 1'h0}};
    always #10 mclk_in = ~mclk_in;
    bxd_excite_drive i_bxd_excite_drive (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
        .ce_in(ce_in), .ac_excite_enable_in(en), .ext_step_sel_in(sel), .ext_step_in(step),
        .excite_phase_a_out(a), .excite_phase_a_n_out(an), .excite_phase_b_out(b),
        .excite_phase_b_n_out(bn), .polarity_reversed_out(pol), .excite_active_out(act));
    bxd_switch_model i_bxd_switch_model (.mclk_in(mclk_in), .sw_a_in(a), .sw_b_in(b),
        .reversed_out(rev), .shorted_out(sh));
    task automatic cmp(input string nm, input logic exp, input logic got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %b seen %b", nm, exp, got);
        end
    endtask
    task automatic outs(input logic ea, input logic eb, input logic ev);
        cmp("phase_a", ea, a);
        cmp("phase_a_n", !ea, an);
        cmp("phase_b", eb, b);
        cmp("phase_b_n", !eb, bn);
        cmp("polarity", !ea, pol);
        cmp("reversed", eb, rev);
        cmp("active", ev, act);
    endtask
    task automatic tally_and_finish;
        $display("Counts: %0d checks, %0d mismatches", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Counts edges until the chosen phase reaches lvl, then checks the count
    task automatic edges(input logic pick_b, input logic lvl, input int exp);
        n = 0;
        while (((pick_b ? b : a) !== lvl) && n < 300) begin
            @(negedge mclk_in);
            n++;
        end
        tests_run++;
        if (n !== exp) begin
            mismatches++;
            $display("ERROR edge count expected %0d seen %0d", exp, n);
        end
        if (n >= 300) begin
            tally_and_finish();
        end
    endtask
    initial begin
        repeat (2) @(negedge mclk_in);
        sys_rst_in = 1'b0;
        foreach (rows[i]) begin
            en = rows[i].en;
            step = rows[i].st;
            repeat (rows[i].cyc) @(negedge mclk_in);
            outs(rows[i].a, rows[i].b, rows[i].act);
        end
        $display("Test stepped rows done");
        sel = 1'b0;
        en = 1'b1;
        edges(1'b0, 1'b0, HALF_PERIOD_CYCLES + 1);
        edges(1'b1, 1'b1, 1);
        ce_in = 1'b0;
        repeat (5) @(negedge mclk_in);
        outs(1'b0, 1'b1, 1'b1);
        ce_in = 1'b1;
        edges(1'b1, 1'b0, HALF_PERIOD_CYCLES);
        edges(1'b0, 1'b1, 1);
        $display("Test timer and freeze done");
        sys_rst_in = 1'b1;
        repeat (2) @(negedge mclk_in);
        outs(1'b1, 1'b0, 1'b0);
        sys_rst_in = 1'b0;
        cmp("shorted", 1'b0, sh);
        $display("Test reset done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
